// ===== design/eewr_top.sv
// Extended write path: staging registers, unlock, write-protect matrix, faults, margin mode.
// Assumes a single AHB-Lite master, word transfers, and an EEPROM macro with done/abort.
//
// Operation
// - Unprotected: general words need unlock; secondary keyless
// - Primary keyless needs keyless and open bits
// - Protected: general refused; user words need bypass
// - Protected bypass: secondary as unprotected; primary needs open bit even unlocked
// - Target is 8-bit staged extended address
// - Lowest staging byte is payload MSB
// - Launch bit writes staged payload to address
// - Completion bit set when write finishes
// - Shadow write takes two cycles after launch sync
// - Done in next byte bit 0; 0x80 launches
// - Refused access ends, sets done, raises warning
// - Aborted EEPROM write sets error fault bit
// - Selector 0001 lowers read threshold
// - Selector 0010 raises read threshold
// - Margin selector persists, readable until cleared
// - Five-byte key sequence enables EEPROM writes
// - Lock 0xC blocks EEPROM, allows shadow writes
// - Lock 0x3 blocks EEPROM and shadow writes
// - Shadow sits 0x40 above EEPROM address
`timescale 1ns/1ps
`include "eewr_map.svh"

module eewr_top
	import eewr_pkg::*;
#(
	parameter int EE_TIMEOUT_CYC = `EEWR_EE_WRITE_MS * `EEWR_CLK_KHZ,
	parameter int TMO_W          = $clog2(EE_TIMEOUT_CYC + 1)
)
(
	// Clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	// EEPROM write port
	output logic                          ee_req,
	output logic [5:0]                    ee_addr,
	output logic [31:0]                   ee_wdata,
	input  wire logic                     ee_done,
	input  wire logic                     ee_abort,
	// Shadow write port
	output logic                          sh_we,
	output logic [5:0]                    sh_addr,
	output logic [31:0]                   sh_wdata,
	// Read threshold selection
	output eewr_pkg::eewr_thresh_e        rd_thresh
);

	import eewr_pkg::*;

	// Bus capture
	logic                wr_pend_reg;
	logic [7:0]          wr_idx_reg;
	logic [31:0]         rdata_reg;
	// Staging and control
	logic [7:0]          waddr_reg;
	logic [7:0]          wdata_reg [0:3];
	logic                launch_reg;
	logic                busy_reg;
	logic                done_reg;
	logic [2:0]          key_step_reg;
	logic                unlocked_reg;
	logic [6:0]          cfg_reg;
	logic [3:0]          test_reg;
	eewr_thresh_e        thresh_reg;
	eewr_thresh_e        thresh_next;
	logic                warn_reg;
	logic                err_reg;
	logic [TMO_W-1:0]    tmo_reg;
	logic [31:0]         tgt_data_reg;
	logic [7:0]          tgt_addr_reg;
	logic                ee_req_reg;
	logic                sh_we_reg;
	eewr_state_e         state_reg;
	eewr_state_e         state_next;

	// Address phase decode
	wire         size_ok   = (hsize == `EEWR_HSIZE_WORD);
	wire         acc_take  = hsel & hready & htrans[1] & size_ok;
	wire [7:0]   acc_idx   = haddr[9:2];
	wire         wr_take   = acc_take & hwrite;
	wire [7:0]   wbyte     = hwdata[7:0];

	// Data phase write strobes
	wire         we_waddr  = wr_pend_reg & (wr_idx_reg == `EEWR_IDX_WADDR);
	wire         we_ctrl   = wr_pend_reg & (wr_idx_reg == `EEWR_IDX_WCTRL);
	wire         we_key    = wr_pend_reg & (wr_idx_reg == `EEWR_IDX_KEY);
	wire         we_cfg    = wr_pend_reg & (wr_idx_reg == `EEWR_IDX_CFG);
	wire         we_test   = wr_pend_reg & (wr_idx_reg == `EEWR_IDX_TEST);
	wire         we_fault  = wr_pend_reg & (wr_idx_reg == `EEWR_IDX_FAULT);
	wire [5:0]   data_blk  = 6'(`EEWR_IDX_WDATA0 >> 2);
	wire         we_data   = wr_pend_reg & (wr_idx_reg[7:2] == data_blk);
	wire [1:0]   data_sel  = wr_idx_reg[1:0];
	wire         launch_wr = we_ctrl & wbyte[`EEWR_LAUNCH_BIT];

	// Payload assembled MSB first from the lowest staging byte
	wire [31:0]  payload   = {wdata_reg[0], wdata_reg[1], wdata_reg[2], wdata_reg[3]};

	// Unlock sequence matching
	wire [7:0]   key_exp   = (key_step_reg == 3'h0) ? `EEWR_KEY0 :
	                         (key_step_reg == 3'h1) ? `EEWR_KEY1 :
	                         (key_step_reg == 3'h2) ? `EEWR_KEY2 :
	                         (key_step_reg == 3'h3) ? `EEWR_KEY3 : `EEWR_KEY4;
	wire         key_hit   = we_key & (wbyte == key_exp);
	wire         key_done  = key_hit & (key_step_reg == `EEWR_KEY_LAST);

	// Protection fields
	wire [3:0]   lock_lvl  = cfg_reg[3:0];
	wire         opt_del   = cfg_reg[`EEWR_CFG_DEL_BIT];
	wire         opt_dur   = cfg_reg[`EEWR_CFG_DUR_BIT];
	wire         opt_cud   = cfg_reg[`EEWR_CFG_CUD_BIT];
	wire         cfg_frozen = (lock_lvl == `EEWR_LOCK_EEPROM) | (lock_lvl == `EEWR_LOCK_ALL);

	// Target classification
	wire [1:0]   tgt_region = tgt_addr_reg[7:6];
	wire [5:0]   tgt_word   = tgt_addr_reg[5:0];
	wire         tgt_shadow = (tgt_region == `EEWR_REG_SHADOW);
	wire         tgt_ee     = (tgt_region == `EEWR_REG_EEPROM);
	wire         tgt_sec    = (tgt_word == `EEWR_USER_SEC);
	wire         tgt_pri    = (tgt_word == `EEWR_USER_PRI);

	// Protection as seen by the target region
	wire         prot_ee    = (lock_lvl == `EEWR_LOCK_EEPROM) | (lock_lvl == `EEWR_LOCK_ALL);
	wire         prot_sh    = (lock_lvl == `EEWR_LOCK_ALL);
	wire         prot       = tgt_shadow ? prot_sh : prot_ee;

	// Exception matrix
	wire         sec_open   = unlocked_reg | opt_dur;
	wire         pri_open   = unlocked_reg | (opt_dur & opt_cud);
	wire         pri_byp    = opt_del & opt_cud & (unlocked_reg | opt_dur);
	wire         sec_byp    = opt_del & (unlocked_reg | opt_dur);
	wire         ok_unprot  = tgt_sec ? sec_open : tgt_pri ? pri_open : unlocked_reg;
	wire         ok_prot    = tgt_sec ? sec_byp : tgt_pri ? pri_byp : 1'b0;
	wire         allowed    = (tgt_ee | tgt_shadow) & (prot ? ok_prot : ok_unprot);

	wire         tmo_hit    = (tmo_reg == TMO_W'(EE_TIMEOUT_CYC - 1));
	wire         ee_fail    = (state_reg == EEWR_ST_EE) & (ee_abort | (tmo_hit & ~ee_done));
	wire         ee_ok      = (state_reg == EEWR_ST_EE) & ee_done & ~ee_abort;
	wire         eval_deny  = (state_reg == EEWR_ST_EVAL) & ~allowed;
	wire         eval_sh    = (state_reg == EEWR_ST_EVAL) & allowed & tgt_shadow;
	wire         eval_ee    = (state_reg == EEWR_ST_EVAL) & allowed & tgt_ee;
	wire         finish     = eval_deny | eval_sh | ee_ok | ee_fail;
	wire         warn_set   = eval_deny | ee_fail;
	wire         start      = (state_reg == EEWR_ST_IDLE) & launch_reg;

	// Read mux
	wire [31:0]  rd_mux =
		(acc_idx == `EEWR_IDX_WADDR)  ? {24'h000000, waddr_reg} :
		(acc_idx == `EEWR_IDX_WDATA0) ? {24'h000000, wdata_reg[0]} :
		(acc_idx == `EEWR_IDX_WDATA1) ? {24'h000000, wdata_reg[1]} :
		(acc_idx == `EEWR_IDX_WDATA2) ? {24'h000000, wdata_reg[2]} :
		(acc_idx == `EEWR_IDX_WDATA3) ? {24'h000000, wdata_reg[3]} :
		(acc_idx == `EEWR_IDX_WCTRL)  ? {31'h00000000, busy_reg} :
		(acc_idx == `EEWR_IDX_WSTAT)  ? {31'h00000000, done_reg} :
		(acc_idx == `EEWR_IDX_KEY)    ? {31'h00000000, unlocked_reg} :
		(acc_idx == `EEWR_IDX_CFG)    ? {25'h0000000, cfg_reg} :
		(acc_idx == `EEWR_IDX_TEST)   ? {28'h0000000, test_reg} :
		(acc_idx == `EEWR_IDX_FAULT)  ? {30'h00000000, err_reg, warn_reg} :
		32'h00000000;

	// Margin threshold decoded from the selector value being written
	wire [3:0]   test_wr   = hwdata[3:0];
	wire         thr_low   = (test_wr == `EEWR_TEST_LOW);
	wire         thr_high  = (test_wr == `EEWR_TEST_HIGH);
	assign thresh_next = thr_low  ? EEWR_THR_LOW :
	                     thr_high ? EEWR_THR_HIGH :
	                     EEWR_THR_NORMAL;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;
	assign ee_req    = ee_req_reg;
	assign ee_addr   = tgt_word;
	assign ee_wdata  = tgt_data_reg;
	assign sh_we     = sh_we_reg;
	assign sh_addr   = tgt_word;
	assign sh_wdata  = tgt_data_reg;
	assign rd_thresh = thresh_reg;

	// Write sequencer
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			EEWR_ST_IDLE: if (launch_reg) state_next = EEWR_ST_EVAL;
			EEWR_ST_EVAL: state_next = eval_ee ? EEWR_ST_EE : EEWR_ST_IDLE;
			EEWR_ST_EE:   if (ee_ok | ee_fail) state_next = EEWR_ST_IDLE;
			default:      state_next = EEWR_ST_IDLE;
		endcase
	end

	// Bus phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			rdata_reg   <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= wr_take;
			if (acc_take)
				wr_idx_reg <= acc_idx;
			if (acc_take & ~hwrite)
				rdata_reg <= rd_mux;
		end
	end

	// Staging registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			waddr_reg    <= `EEWR_RST_BYTE;
			wdata_reg[0] <= `EEWR_RST_BYTE;
			wdata_reg[1] <= `EEWR_RST_BYTE;
			wdata_reg[2] <= `EEWR_RST_BYTE;
			wdata_reg[3] <= `EEWR_RST_BYTE;
		end
		else
		begin
			if (we_waddr)
				waddr_reg <= wbyte;
			if (we_data)
				wdata_reg[data_sel] <= wbyte;
		end
	end

	// Launch, unlock, configuration and margin selector
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			launch_reg   <= 1'b0;
			key_step_reg <= 3'h0;
			unlocked_reg <= 1'b0;
			cfg_reg      <= `EEWR_RST_CFG;
			test_reg     <= `EEWR_RST_TEST;
		end
		else
		begin
			launch_reg <= launch_wr & ~busy_reg;
			if (key_done)
				unlocked_reg <= 1'b1;
			if (key_hit & ~key_done)
				key_step_reg <= key_step_reg + 3'h1;
			else if (we_key)
				key_step_reg <= (wbyte == `EEWR_KEY0) ? 3'h1 : 3'h0;
			if (we_cfg & ~cfg_frozen)
				cfg_reg <= hwdata[6:0];
			if (we_test)
				test_reg <= test_wr;
		end
	end

	// Sequencer state, outputs and status
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg    <= EEWR_ST_IDLE;
			busy_reg     <= 1'b0;
			done_reg     <= 1'b0;
			tgt_addr_reg <= 8'h00;
			tgt_data_reg <= 32'h00000000;
			ee_req_reg   <= 1'b0;
			sh_we_reg    <= 1'b0;
			tmo_reg      <= '0;
		end
		else
		begin
			state_reg <= state_next;
			sh_we_reg <= eval_sh;
			if (start)
			begin
				busy_reg     <= 1'b1;
				done_reg     <= 1'b0;
				tgt_addr_reg <= waddr_reg;
				tgt_data_reg <= payload;
			end
			else if (finish)
			begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
			if (eval_ee)
				ee_req_reg <= 1'b1;
			else if (ee_ok | ee_fail)
				ee_req_reg <= 1'b0;
			tmo_reg <= (state_reg == EEWR_ST_EE) ? tmo_reg + TMO_W'(1) : '0;
		end
	end

	// Fault flags, write one to clear, a new event wins over the clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			warn_reg <= 1'b0;
			err_reg  <= 1'b0;
		end
		else
		begin
			if (warn_set)
				warn_reg <= 1'b1;
			else if (we_fault & hwdata[`EEWR_FLT_WARN_BIT])
				warn_reg <= 1'b0;
			if (ee_fail)
				err_reg <= 1'b1;
			else if (we_fault & hwdata[`EEWR_FLT_ERR_BIT])
				err_reg <= 1'b0;
		end
	end

	// Threshold kept in a flip-flop, reloaded with every selector write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			thresh_reg <= EEWR_THR_NORMAL;
		else if (we_test)
			thresh_reg <= thresh_next;
	end

endmodule : eewr_top

// ===== design/eewr_map.svh
// Constants for the extended write block: register indices, fields, codes and timing.
// Assumes inclusion by the design file; the package does not include it.
`ifndef EEWR_MAP_SVH
`define EEWR_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define EEWR_IDX_WADDR    8'h02
`define EEWR_IDX_WDATA0   8'h04
`define EEWR_IDX_WDATA1   8'h05
`define EEWR_IDX_WDATA2   8'h06
`define EEWR_IDX_WDATA3   8'h07
`define EEWR_IDX_WCTRL    8'h08
`define EEWR_IDX_WSTAT    8'h09
`define EEWR_IDX_KEY      8'h3c
`define EEWR_IDX_CFG      8'h40
`define EEWR_IDX_TEST     8'h41
`define EEWR_IDX_FAULT    8'h42

// Field positions
`define EEWR_LAUNCH_BIT   7
`define EEWR_BUSY_BIT     0
`define EEWR_DONE_BIT     0
`define EEWR_CFG_DEL_BIT  4
`define EEWR_CFG_DUR_BIT  5
`define EEWR_CFG_CUD_BIT  6
`define EEWR_FLT_WARN_BIT 0
`define EEWR_FLT_ERR_BIT  1
`define EEWR_HSIZE_WORD   3'h2

// Unlock key bytes, in order
`define EEWR_KEY0         8'h00
`define EEWR_KEY1         8'h27
`define EEWR_KEY2         8'h81
`define EEWR_KEY3         8'h1f
`define EEWR_KEY4         8'h77
`define EEWR_KEY_LAST     3'h4

// Extended map
`define EEWR_USER_SEC     6'h17
`define EEWR_USER_PRI     6'h1f
`define EEWR_REG_EEPROM   2'h0
`define EEWR_REG_SHADOW   2'h1
`define EEWR_LOCK_NONE    4'h0
`define EEWR_LOCK_EEPROM  4'hc
`define EEWR_LOCK_ALL     4'h3

// Margin selector codes
`define EEWR_TEST_LOW     4'h1
`define EEWR_TEST_HIGH    4'h2

// Reset values
`define EEWR_RST_BYTE     8'h00
`define EEWR_RST_CFG      7'h00
`define EEWR_RST_TEST     4'h0

// Timing
`define EEWR_EE_WRITE_MS  24
`define EEWR_CLK_KHZ      100000

`endif

// ===== design/eewr_pkg.sv
// Types for the extended write block.
// Assumes the constants header is on the include path.
package eewr_pkg;

	typedef enum logic [2:0]
	{
		EEWR_ST_IDLE = 3'b001,
		EEWR_ST_EVAL = 3'b010,
		EEWR_ST_EE   = 3'b100
	} eewr_state_e;

	typedef enum logic [1:0]
	{
		EEWR_THR_NORMAL = 2'b00,
		EEWR_THR_LOW    = 2'b01,
		EEWR_THR_HIGH   = 2'b10
	} eewr_thresh_e;

endpackage : eewr_pkg

// ===== tb/eewr_props.sv
// Checker for the extended write block, bound into its top module.
// Assumes the top module's ports and the package types.
`timescale 1ns/1ps
module eewr_props
	import eewr_pkg::*;
#(
	parameter int EE_TIMEOUT_CYC = 20,
	parameter int TMO_W          = 5
)
(
	// Clock, reset and bus
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  hsel,
	input wire logic                  hwrite,
	input wire logic                  hready,
	input wire logic [31:0]           haddr,
	input wire logic [31:0]           hwdata,
	input wire logic [1:0]            htrans,
	input wire logic [2:0]            hsize,
	input wire logic                  hresp,
	// Write ports and threshold
	input wire logic                  ee_req,
	input wire logic                  ee_done,
	input wire logic                  ee_abort,
	input wire logic [5:0]            ee_addr,
	input wire logic [31:0]           ee_wdata,
	input wire logic                  sh_we,
	input wire eewr_pkg::eewr_thresh_e rd_thresh
);
	import eewr_pkg::*;
	logic             wdp;
	logic [7:0]       wa;
	logic [TMO_W+1:0] cnt;
	wire lnch = wdp && wa == 8'h08 && hwdata[7];
	wire msel = wdp && wa == 8'h41;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wdp <= 1'b0;
			wa <= 8'h00;
			cnt <= '0;
		end
		else
		begin
			wdp <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
			wa <= haddr[9:2];
			cnt <= ee_req ? cnt + 1'b1 : '0;
		end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_sh_pulse: assert property (sh_we |=> !sh_we)
		else $error("shadow strobe too long");
	a_ee_stable: assert property (ee_req && $past(ee_req) |-> $stable(ee_addr) && $stable(ee_wdata))
		else $error("eeprom request moved");
	a_ee_end: assert property (ee_req && (ee_done || ee_abort) |=> !ee_req)
		else $error("eeprom request not ended");
	a_ee_bound: assert property (cnt <= EE_TIMEOUT_CYC + 3)
		else $error("eeprom request overran");
	a_launch_cause: assert property (sh_we || $rose(ee_req) |-> $past(lnch, 3))
		else $error("write without launch");
	a_thr_low: assert property (msel && hwdata[3:0] == 4'h1 |=> rd_thresh == EEWR_THR_LOW)
		else $error("low threshold missing");
	a_thr_high: assert property (msel && hwdata[3:0] == 4'h2 |=> rd_thresh == EEWR_THR_HIGH)
		else $error("high threshold missing");
	a_thr_hold: assert property (!msel |=> $stable(rd_thresh))
		else $error("threshold changed alone");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	c_shadow: cover property (sh_we);
	c_done: cover property (ee_req && ee_done);
	c_abort: cover property (ee_req && ee_abort);
endmodule : eewr_props

bind eewr_top eewr_props #(.EE_TIMEOUT_CYC(EE_TIMEOUT_CYC), .TMO_W(TMO_W)) eewr_props_inst (
	.hclk, .hresetn, .hsel, .hwrite, .hready, .haddr, .hwdata, .htrans, .hsize, .hresp,
	.ee_req, .ee_done, .ee_abort, .ee_addr, .ee_wdata, .sh_we, .rd_thresh);

// ===== tb/eewr_ee_model.sv
// Model of the EEPROM macro behind the write port: done, abort or no answer after a delay.
// Assumes the bench picks the delay and the fault mode.
`timescale 1ns/1ps
module eewr_ee_model
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Write port and mode
	input  wire logic       ee_req,
	input  wire logic [2:0] dly,
	input  wire logic       ab,
	input  wire logic       sil,
	output logic            ee_done,
	output logic            ee_abort
);
	logic [4:0] n;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			n <= 5'h00;
			ee_done <= 1'b0;
			ee_abort <= 1'b0;
		end
		else
		begin
			n <= ee_req ? n + 5'h01 : 5'h00;
			ee_done <= ee_req && !ab && !sil && n == dly;
			ee_abort <= ee_req && ab && n == dly;
		end
endmodule : eewr_ee_model

// ===== tb/tb_eewr_top.sv
// Testbench for the extended write block: staging, unlock, matrix, faults, margin.
// Assumes the EEPROM model beside the design and the checker bound in.
`timescale 1ns/1ps
module tb_eewr_top;
	import eewr_pkg::*;
	logic         hclk, hresetn, hready, hresp, ee_req, ee_done, ee_abort, sh_we;
	logic         hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, ee_q = 1'b0, ab = 1'b0, sil = 1'b0;
	logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, ee_wdata, sh_wdata, sd = 32'h94514358;
	logic [1:0]   htrans = 2'h0;
	logic [2:0]   hsize = 3'h2;
	logic [5:0]   ee_addr, sh_addr;
	eewr_thresh_e rd_thresh;
	logic [37:0]  q[$];
	int           n_mismatch = 0, compares = 0;
	eewr_top #(.EE_TIMEOUT_CYC(20)) eewr_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .ee_req,
		.ee_addr, .ee_wdata, .ee_done, .ee_abort, .sh_we, .sh_addr, .sh_wdata, .rd_thresh);
	eewr_ee_model eewr_ee_model_inst (.hclk, .hresetn, .ee_req, .dly(sd[2:0]), .ab, .sil,
		.ee_done, .ee_abort);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic stop_test;
		$display("errors %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [37:0] got);
		logic [37:0] e;
		e = ~got;
		compares++;
		if (q.size() != 0)
			e = q.pop_front();
		if (got !== e)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, got, e);
		end
	endtask : cmp
	always @(posedge hclk)
	begin
		if (rd_ph)
			cmp({6'h00, hrdata});
		if (sh_we === 1'b1)
			cmp({sh_addr, sh_wdata});
		if (ee_req === 1'b1 && !ee_q)
			cmp({ee_addr, ee_wdata});
		ee_q <= ee_req;
	end
	task automatic wt;
		int i;
		i = 0;
		do
		begin
			@(posedge hclk);
			i++;
		end
		while (hready !== 1'b1 && i < 20);
		if (hready !== 1'b1)
		begin
			n_mismatch++;
			stop_test;
		end
	endtask : wt
	task automatic xfer(input logic w, c, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wt;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rd_ph <= !w && c;
		wt;
		rd_ph <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [31:0] a, d);
		xfer(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [31:0] a, e);
		q.push_back({6'h00, e});
		xfer(1'b0, 1'b1, a, 32'h0);
	endtask : rd
	task automatic ext(input logic [7:0] t, input logic p, input logic [31:0] f);
		int i;
		sd = xs(sd);
		wr(32'h8, {24'h0, t});
		for (i = 0; i < 4; i++)
			wr(32'h10 + 4 * i, {24'h0, sd[31 - 8 * i -: 8]});
		if (p)
			q.push_back({t[5:0], sd});
		wr(32'h20, 32'h80);
		xfer(1'b0, 1'b0, 32'h20, 32'h0);
		i = 0;
		do
		begin
			xfer(1'b0, 1'b0, 32'h24, 32'h0);
			i++;
		end
		while (hrdata[0] !== 1'b1 && i < 60);
		if (hrdata[0] !== 1'b1)
		begin
			n_mismatch++;
			stop_test;
		end
		rd(32'h108, f);
		wr(32'h108, 32'h3);
	endtask : ext
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial
	begin
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(32'h100, 32'h0);
		rd(32'h0f0, 32'h0);
		rd(32'h300, 32'h0);
		for (int k = 1; k < 4; k++)
		begin
			wr(32'h104, k % 3);
			rd(32'h104, k % 3);
		end
		ext(8'h05, 1'b0, 32'h1);
		ext(8'h45, 1'b0, 32'h1);
		wr(32'h100, 32'h20);
		ext(8'h17, 1'b1, 32'h0);
		ext(8'h1f, 1'b0, 32'h1);
		wr(32'h100, 32'h60);
		ext(8'h1f, 1'b1, 32'h0);
		ext(8'h80, 1'b0, 32'h1);
		wr(32'h100, 32'h0);
		wr(32'h0f0, 32'h27);
		for (int k = 0; k < 5; k++)
			wr(32'h0f0, {24'h0, 8'(40'h00_27_81_1f_77 >> (32 - 8 * k))});
		rd(32'h0f0, 32'h1);
		ext(8'h05, 1'b1, 32'h0);
		for (int k = 1; k < 3; k++)
		begin
			wr(32'h104, k);
			rd(32'h104, k);
		end
		wr(32'h104, 32'h0);
		ext(8'h05, 1'b1, 32'h0);
		ext(8'h57, 1'b1, 32'h0);
		ab <= 1'b1;
		ext(8'h05, 1'b1, 32'h3);
		ab <= 1'b0;
		sil <= 1'b1;
		ext(8'h05, 1'b1, 32'h3);
		sil <= 1'b0;
		wr(32'h100, 32'h3c);
		wr(32'h100, 32'h0);
		rd(32'h100, 32'h3c);
		ext(8'h05, 1'b0, 32'h1);
		ext(8'h17, 1'b1, 32'h0);
		ext(8'h1f, 1'b0, 32'h1);
		ext(8'h45, 1'b1, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(32'h0f0, 32'h0);
		wr(32'h100, 32'h33);
		ext(8'h45, 1'b0, 32'h1);
		ext(8'h57, 1'b1, 32'h0);
		stop_test;
	end
endmodule : tb_eewr_top
